// ---- include/bhb_pkg.sv ----
package bhb_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SFCFG = 8'h04;
  localparam logic [7:0] REG_SEQ = 8'h08;
  localparam logic [7:0] REG_NETID = 8'h0c;
  localparam logic [7:0] REG_ADDR_LO = 8'h10;
  localparam logic [7:0] REG_ADDR_HI = 8'h14;
  localparam logic [7:0] REG_SEC_CTRL = 8'h18;
  localparam logic [7:0] REG_SEC_CNT = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_TX_SPEC = 8'h24;
  localparam logic [7:0] REG_RX_SPEC = 8'h28;
  localparam logic [7:0] REG_RX_SRC = 8'h2c;

  // CTRL bits
  localparam int CTRL_START = 0;
  localparam int CTRL_SEC = 1;
  localparam int CTRL_LONG = 2;
  localparam int CTRL_COORD = 3;
  localparam int CTRL_ASSOC = 4;
  localparam int CTRL_SLOTP = 5;
  localparam int CTRL_CSE = 6;
  localparam int CTRL_PEND = 7;
  localparam int CTRL_MAINT = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;

  // SFCFG fields
  localparam int CFG_BO = 0;
  localparam int CFG_SO = 4;
  localparam int CFG_FCAP = 8;
  localparam int CFG_DCNT = 12;
  localparam int CFG_CELL = 16;

  // STATUS bits
  localparam int ST_BUSY = 0;
  localparam int ST_CAP_SHORT = 1;
  localparam int ST_RX_DONE = 2;
  localparam int ST_RX_NOT_BCN = 3;
  localparam int ST_RX_CELL = 4;
  localparam int ST_RX_SLOTS = 5;

  // ----------------------------------------------------------------
  // frame control, superframe spec, slot-allocation spec layouts
  // ----------------------------------------------------------------
  localparam int FC_TYPE = 0;
  localparam int FC_SEC = 3;
  localparam int FC_PEND = 4;
  localparam int FC_SRCM = 14;
  localparam logic [2:0] FT_BEACON = 3'h0;
  localparam logic [1:0] SRCM_SHORT = 2'h2;
  localparam logic [1:0] SRCM_LONG = 2'h3;
  localparam logic [15:0] FC_KEEP = 16'hc01f;
  localparam int SF_BO = 0;
  localparam int SF_SO = 4;
  localparam int SF_FCAP = 8;
  localparam int SF_COORD = 13;
  localparam int SF_ASSOC = 14;
  localparam int SF_CSE = 15;
  localparam logic [15:0] SF_KEEP = 16'hefff;
  localparam int GS_DCNT = 0;
  localparam int GS_PERMIT = 7;
  localparam logic [7:0] GS_KEEP = 8'h87;
  localparam logic [3:0] MIN_CAP_SLOTS = 4'h8;

  // field walker shared by builder and parser
  typedef enum logic [3:0] {
    F_IDLE = 4'h0,
    F_FC = 4'h1,
    F_SEQ = 4'h3,
    F_NETID = 4'h2,
    F_ADDR = 4'h6,
    F_SEC = 4'h7,
    F_SF = 4'h5,
    F_GTS = 4'h4,
    F_CELL = 4'hc
  } bhb_field_t;

  function automatic logic [3:0] field_len(bhb_field_t f, logic long_a);
    unique case (f)
      F_FC: field_len = 4'h2;
      F_NETID: field_len = 4'h2;
      F_ADDR: field_len = long_a ? 4'h8 : 4'h2;
      F_SEC: field_len = 4'h5;
      F_SF: field_len = 4'h2;
      default: field_len = 4'h1;
    endcase
  endfunction

  function automatic bhb_field_t next_field(bhb_field_t f, logic sec,
                                            logic cse);
    unique case (f)
      F_FC: next_field = F_SEQ;
      F_SEQ: next_field = F_NETID;
      F_NETID: next_field = F_ADDR;
      F_ADDR: next_field = sec ? F_SEC : F_SF;
      F_SEC: next_field = F_SF;
      F_SF: next_field = F_GTS;
      F_GTS: next_field = cse ? F_CELL : F_IDLE;
      default: next_field = F_IDLE;
    endcase
  endfunction

endpackage

// ---- include/bhb_rx_if.sv ----
`timescale 1ns/1ns
interface bhb_rx_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic start;
  logic valid;
  logic [7:0] data;
  logic done;
  logic not_beacon;
  logic [7:0] seq;
  logic [15:0] netid;
  logic [15:0] src16;
  logic [15:0] sf;
  logic [7:0] guaranteed_time_slot;

  modport core (
    input clk, rst_n, done, not_beacon, seq, netid, src16, sf, guaranteed_time_slot,
    output start, valid, data
  );
  modport rx (
    input clk, rst_n, start, valid, data,
    output done, not_beacon, seq, netid, src16, sf, guaranteed_time_slot
  );
endinterface

// ---- core/bhb_rx.sv ----
`timescale 1ns/1ns
module bhb_rx (
  bhb_rx_if.rx rx
);

  typedef struct packed {
    bhb_pkg::bhb_field_t st;
    logic [3:0] k;
    logic [15:0] fc;
    logic [7:0] seq;
    logic [15:0] netid;
    logic [15:0] src16;
    logic [15:0] sf;
    logic [7:0] guaranteed_time_slot;
    logic done;
    logic not_beacon;
  } bhb_rx_st_t;

  bhb_rx_st_t s_q;
  bhb_rx_st_t s_d;

  always_comb begin
    logic long_a;
    logic sec;
    long_a = 1'b0;
    sec = 1'b0;
    s_d = s_q;
    s_d.done = 1'b0;
    if (rx.start) begin
      s_d.st = bhb_pkg::F_FC;
      s_d.k = 4'h0;
      s_d.not_beacon = 1'b0;
    end else if (rx.valid && s_q.st != bhb_pkg::F_IDLE) begin
      unique case (s_q.st)
        bhb_pkg::F_FC: begin
          // unassigned subfields are dropped on capture
          if (s_q.k == 4'h0) begin
            s_d.fc[7:0] = rx.data & bhb_pkg::FC_KEEP[7:0]; // [R4]
          end else begin
            s_d.fc[15:8] = rx.data & bhb_pkg::FC_KEEP[15:8]; // [R4]
          end
        end
        bhb_pkg::F_SEQ: s_d.seq = rx.data;
        bhb_pkg::F_NETID: begin
          if (s_q.k == 4'h0) begin
            s_d.netid[7:0] = rx.data;
          end else begin
            s_d.netid[15:8] = rx.data;
          end
        end
        bhb_pkg::F_ADDR: begin
          if (s_q.k == 4'h0) begin
            s_d.src16[7:0] = rx.data;
          end else if (s_q.k == 4'h1) begin
            s_d.src16[15:8] = rx.data;
          end
        end
        bhb_pkg::F_SF: begin
          if (s_q.k == 4'h0) begin
            s_d.sf[7:0] = rx.data & bhb_pkg::SF_KEEP[7:0];
          end else begin
            s_d.sf[15:8] = rx.data & bhb_pkg::SF_KEEP[15:8]; // [R18]
          end
        end
        bhb_pkg::F_GTS: s_d.guaranteed_time_slot = rx.data & bhb_pkg::GS_KEEP; // [R18]
        default: ;
      endcase
      long_a = s_d.fc[bhb_pkg::FC_SRCM +: 2] == bhb_pkg::SRCM_LONG;
      sec = s_d.fc[bhb_pkg::FC_SEC];
      if (s_q.k + 4'h1 == bhb_pkg::field_len(s_q.st, long_a)) begin
        // parsing stops at the slot-allocation spec; what follows
        // depends on the count and the cell-search bit [R14] [R16]
        s_d.st = bhb_pkg::next_field(s_q.st, sec, 1'b0);
        s_d.k = 4'h0;
      end else begin
        s_d.k = s_q.k + 4'h1;
      end
      if (s_q.st == bhb_pkg::F_FC && s_q.k == 4'h1 &&
          s_d.fc[bhb_pkg::FC_TYPE +: 3] != bhb_pkg::FT_BEACON) begin
        s_d.not_beacon = 1'b1;
        s_d.st = bhb_pkg::F_IDLE;
      end
      if (s_q.st == bhb_pkg::F_GTS) begin
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge rx.clk or negedge rx.rst_n) begin
    if (!rx.rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rx.done = s_q.done;
  assign rx.not_beacon = s_q.not_beacon;
  assign rx.seq = s_q.seq;
  assign rx.netid = s_q.netid;
  assign rx.src16 = s_q.src16;
  assign rx.sf = s_q.sf;
  assign rx.guaranteed_time_slot = s_q.guaranteed_time_slot;

endmodule

// ---- core/bhb_top.sv ----
`timescale 1ns/1ns
// Contract
// [R1] header order: control, sequence, network id, address
// [R2] beacon frame type, source mode matches address
// [R3] security enabled bit set when protected
// [R4] unassigned control bits zero, ignored on receive
// [R5] sequence octet from beacon_seq_counter
// [R6] network id and address of sender
// [R7] auxiliary security header carries security parameters
// [R8] superframe bits 0-3 beacon order
// [R9] superframe bits 4-7 superframe order
// [R10] superframe bits 8-11 final contention slot
// [R11] contention period not below minimum, maintenance excepted; code only refuses a short one when the slot count is zero
// [R12] bit 13 set when coordinator sends
// [R13] bit 14 copies association_permit_attr
// [R14] cell-search length octet only when bit 15
// [R15] slot spec: count 0-2, reserved, permit 7
// [R16] zero count omits slot-direction and slot-list
// [R17] permit bit follows slot_permit_attr
// [R18] reserved superframe and slot bits zero, ignored
module bhb_top #(
  parameter logic [3:0] MIN_CAP_SLOTS = bhb_pkg::MIN_CAP_SLOTS
) (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  output logic TX_LAST_O,
  output logic TX_SLOTS_FOLLOW_O,
  input wire logic TX_READY_I,
  input wire logic RX_START_I,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_DATA_I
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
    logic [8:1] ctrl;
    logic [23:0] sfcfg;
    logic [7:0] seq;
    logic [15:0] netid;
    logic [63:0] addr;
    logic [7:0] sec_ctrl;
    logic [31:0] sec_cnt;
    logic cap_short;
    logic rx_done;
    bhb_pkg::bhb_field_t st;
    logic [3:0] k;
    logic valid;
    logic last;
    logic [7:0] data;
    logic [15:0] b_fc;
    logic [7:0] b_seq;
    logic [15:0] b_netid;
    logic [63:0] b_addr;
    logic [39:0] b_sec;
    logic [15:0] b_sf;
    logic [7:0] b_gts;
    logic [7:0] b_cell;
  } bhb_top_st_t;

  bhb_top_st_t s_q;
  bhb_top_st_t s_d;

  bhb_rx_if rxi (
    .clk(CLK_I),
    .rst_n(rst_n_q)
  );

  bhb_rx u_rx (
    .rx(rxi.rx)
  );

  assign rxi.start = RX_START_I;
  assign rxi.valid = RX_VALID_I;
  assign rxi.data = RX_DATA_I;

  // ----------------------------------------------------------------
  // header octet of a field position, from the frozen snapshot
  // ----------------------------------------------------------------
  function automatic logic [7:0] octet(bhb_top_st_t s,
                                       bhb_pkg::bhb_field_t f,
                                       logic [3:0] k);
    logic [63:0] sh;
    sh = '0;
    octet = 8'h00;
    unique case (f)
      bhb_pkg::F_FC: octet = k[0] ? s.b_fc[15:8] : s.b_fc[7:0];
      bhb_pkg::F_SEQ: octet = s.b_seq;
      bhb_pkg::F_NETID: octet = k[0] ? s.b_netid[15:8] : s.b_netid[7:0];
      bhb_pkg::F_ADDR: begin
        sh = s.b_addr >> {k[2:0], 3'h0};
        octet = sh[7:0];
      end
      bhb_pkg::F_SEC: begin
        sh = {24'h000000, s.b_sec} >> {k[2:0], 3'h0};
        octet = sh[7:0];
      end
      bhb_pkg::F_SF: octet = k[0] ? s.b_sf[15:8] : s.b_sf[7:0];
      bhb_pkg::F_GTS: octet = s.b_gts;
      bhb_pkg::F_CELL: octet = s.b_cell;
      default: octet = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [15:0] fc_w;
  logic [15:0] sf_w;
  logic [7:0] gts_w;
  logic [8:1] ctrl_w;
  logic cap_bad;

  always_comb begin
    // the control write that starts a beacon also configures it
    ctrl_w = (s_q.ph_wr && s_q.ph_addr == bhb_pkg::REG_CTRL) ?
      HWDATA_I[8:1] : s_q.ctrl;
    fc_w = '0; // [R4]
    fc_w[bhb_pkg::FC_TYPE +: 3] = bhb_pkg::FT_BEACON; // [R2]
    fc_w[bhb_pkg::FC_SEC] = ctrl_w[bhb_pkg::CTRL_SEC]; // [R3]
    fc_w[bhb_pkg::FC_PEND] = ctrl_w[bhb_pkg::CTRL_PEND];
    fc_w[bhb_pkg::FC_SRCM +: 2] = ctrl_w[bhb_pkg::CTRL_LONG] ?
      bhb_pkg::SRCM_LONG : bhb_pkg::SRCM_SHORT; // [R2]
    sf_w = '0; // [R18]
    sf_w[bhb_pkg::SF_BO +: 4] = s_q.sfcfg[bhb_pkg::CFG_BO +: 4]; // [R8]
    sf_w[bhb_pkg::SF_SO +: 4] = s_q.sfcfg[bhb_pkg::CFG_SO +: 4]; // [R9]
    sf_w[bhb_pkg::SF_FCAP +: 4] = s_q.sfcfg[bhb_pkg::CFG_FCAP +: 4]; // [R10]
    sf_w[bhb_pkg::SF_COORD] = ctrl_w[bhb_pkg::CTRL_COORD]; // [R12]
    sf_w[bhb_pkg::SF_ASSOC] = ctrl_w[bhb_pkg::CTRL_ASSOC]; // [R13]
    sf_w[bhb_pkg::SF_CSE] = ctrl_w[bhb_pkg::CTRL_CSE]; // [R14]
    gts_w = '0; // [R18]
    gts_w[bhb_pkg::GS_DCNT +: 3] = s_q.sfcfg[bhb_pkg::CFG_DCNT +: 3]; // [R15]
    gts_w[bhb_pkg::GS_PERMIT] = ctrl_w[bhb_pkg::CTRL_SLOTP]; // [R15] [R17]
    // slots 0..final belong to the contention period
    cap_bad = ({1'b0, s_q.sfcfg[bhb_pkg::CFG_FCAP +: 4]} + 5'h01 <
               {1'b0, MIN_CAP_SLOTS}) &&
              !ctrl_w[bhb_pkg::CTRL_MAINT] &&
              (s_q.sfcfg[bhb_pkg::CFG_DCNT +: 3] == 3'h0); // [R11]
  end

  always_comb begin
    logic [31:0] rd;
    logic rd_req;
    logic start;
    logic wr;
    bhb_pkg::bhb_field_t nf;
    rd = 32'h00000000;
    nf = bhb_pkg::F_IDLE;
    s_d = s_q;
    wr = s_q.ph_wr;
    start = wr && s_q.ph_addr == bhb_pkg::REG_CTRL &&
            HWDATA_I[bhb_pkg::CTRL_START];

    // address phase; only whole-word singles are expected
    rd_req = HSEL_I && HREADY_I && HTRANS_I[1];
    s_d.ph_wr = rd_req && HWRITE_I;
    s_d.ph_addr = {HADDR_I[7:2], 2'h0};
    unique case ({HADDR_I[7:2], 2'h0})
      bhb_pkg::REG_CTRL: rd = {23'h000000, s_q.ctrl, 1'b0};
      bhb_pkg::REG_SFCFG: rd = {8'h00, s_q.sfcfg};
      bhb_pkg::REG_SEQ: rd = {24'h000000, s_q.seq};
      bhb_pkg::REG_NETID: rd = {16'h0000, s_q.netid};
      bhb_pkg::REG_ADDR_LO: rd = s_q.addr[31:0];
      bhb_pkg::REG_ADDR_HI: rd = s_q.addr[63:32];
      bhb_pkg::REG_SEC_CTRL: rd = {24'h000000, s_q.sec_ctrl};
      bhb_pkg::REG_SEC_CNT: rd = s_q.sec_cnt;
      bhb_pkg::REG_STATUS: begin
        rd[bhb_pkg::ST_BUSY] = s_q.st != bhb_pkg::F_IDLE;
        rd[bhb_pkg::ST_CAP_SHORT] = s_q.cap_short;
        rd[bhb_pkg::ST_RX_DONE] = s_q.rx_done;
        rd[bhb_pkg::ST_RX_NOT_BCN] = rxi.not_beacon;
        rd[bhb_pkg::ST_RX_CELL] = rxi.sf[bhb_pkg::SF_CSE]; // [R14]
        rd[bhb_pkg::ST_RX_SLOTS] =
          rxi.guaranteed_time_slot[bhb_pkg::GS_DCNT +: 3] != 3'h0; // [R16]
      end
      bhb_pkg::REG_TX_SPEC: rd = {8'h00, gts_w, sf_w};
      bhb_pkg::REG_RX_SPEC: rd = {rxi.seq, rxi.guaranteed_time_slot, rxi.sf};
      bhb_pkg::REG_RX_SRC: rd = {rxi.src16, rxi.netid};
      default: rd = 32'h00000000;
    endcase
    s_d.hrdata = (rd_req && !HWRITE_I) ? rd : 32'h00000000;

    // counter advances once the last header octet has left [R5]
    if (s_q.valid && TX_READY_I && s_q.last) begin
      s_d.seq = s_q.seq + 8'h01;
    end

    // data phase writes
    if (wr) begin
      unique case (s_q.ph_addr)
        bhb_pkg::REG_CTRL: s_d.ctrl = HWDATA_I[8:1];
        bhb_pkg::REG_SFCFG: s_d.sfcfg = HWDATA_I[23:0];
        bhb_pkg::REG_SEQ: s_d.seq = HWDATA_I[7:0];
        bhb_pkg::REG_NETID: s_d.netid = HWDATA_I[15:0];
        bhb_pkg::REG_ADDR_LO: s_d.addr[31:0] = HWDATA_I;
        bhb_pkg::REG_ADDR_HI: s_d.addr[63:32] = HWDATA_I;
        bhb_pkg::REG_SEC_CTRL: s_d.sec_ctrl = HWDATA_I[7:0];
        bhb_pkg::REG_SEC_CNT: s_d.sec_cnt = HWDATA_I;
        bhb_pkg::REG_STATUS: begin
          if (HWDATA_I[bhb_pkg::ST_CAP_SHORT]) begin
            s_d.cap_short = 1'b0;
          end
          if (HWDATA_I[bhb_pkg::ST_RX_DONE]) begin
            s_d.rx_done = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // sticky sets come after the clears so a same-cycle event wins
    if (rxi.done) begin
      s_d.rx_done = 1'b1;
    end

    // builder: walk the header one octet per accepted handshake
    if (s_q.st == bhb_pkg::F_IDLE) begin
      if (start && cap_bad) begin
        s_d.cap_short = 1'b1; // [R11]
      end else if (start) begin
        // snapshot so register writes cannot tear a beacon
        s_d.b_fc = fc_w;
        s_d.b_seq = s_q.seq; // [R5]
        s_d.b_netid = s_q.netid; // [R6]
        s_d.b_addr = s_q.addr; // [R6]
        s_d.b_sec = {s_q.sec_cnt, s_q.sec_ctrl}; // [R7]
        s_d.b_sf = sf_w;
        s_d.b_gts = gts_w;
        s_d.b_cell = s_q.sfcfg[bhb_pkg::CFG_CELL +: 8];
        s_d.st = bhb_pkg::F_FC; // [R1]
        s_d.k = 4'h0;
        s_d.valid = 1'b1;
        s_d.last = 1'b0;
        s_d.data = fc_w[7:0];
      end
    end else if (s_q.valid && TX_READY_I) begin
      if (s_q.k + 4'h1 ==
          bhb_pkg::field_len(s_q.st, s_q.b_fc[bhb_pkg::FC_SRCM +: 2] ==
                             bhb_pkg::SRCM_LONG)) begin
        nf = bhb_pkg::next_field(s_q.st, s_q.b_fc[bhb_pkg::FC_SEC],
                                 s_q.b_sf[bhb_pkg::SF_CSE]); // [R1] [R14]
        s_d.st = nf;
        s_d.k = 4'h0;
      end else begin
        s_d.k = s_q.k + 4'h1;
      end
      s_d.valid = s_d.st != bhb_pkg::F_IDLE;
      s_d.data = octet(s_q, s_d.st, s_d.k);
      s_d.last = s_d.valid &&
        (s_d.k + 4'h1 == bhb_pkg::field_len(s_d.st,
          s_q.b_fc[bhb_pkg::FC_SRCM +: 2] == bhb_pkg::SRCM_LONG)) &&
        bhb_pkg::next_field(s_d.st, s_q.b_fc[bhb_pkg::FC_SEC],
          s_q.b_sf[bhb_pkg::SF_CSE]) == bhb_pkg::F_IDLE;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign HRDATA_O = s_q.hrdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign TX_DATA_O = s_q.data;
  assign TX_VALID_O = s_q.valid;
  assign TX_LAST_O = s_q.last;
  // upstream inserts directions and list only for a nonzero count
  assign TX_SLOTS_FOLLOW_O = s_q.st != bhb_pkg::F_IDLE &&
    s_q.b_gts[bhb_pkg::GS_DCNT +: 3] != 3'h0; // [R16]

endmodule

// ---- tb/bhb_sink_model.sv ----
`timescale 1ns/1ns
module bhb_sink_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic last_i,
  input wire logic slow_i,
  output logic ready_o
);
  logic [7:0] q[$];
  int frames = 0;
  logic [1:0] ph_q = 2'h0;

  initial ready_o = 1'b0;

  // slow mode takes one octet in four, to exercise the hold
  always @(posedge clk_i) begin
    if (rst_n_i) begin
      if (valid_i && ready_o) begin
        q.push_back(data_i);
        if (last_i) frames++;
      end
      ph_q <= ph_q + 2'h1;
      ready_o <= !slow_i || (ph_q == 2'h3);
    end
  end
endmodule

// ---- tb/bhb_top_sva.sv ----
`timescale 1ns/1ns
module bhb_top_sva #(
  parameter logic [3:0] MIN_CAP_SLOTS = 4'h8
) (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic TX_VALID_O,
  input wire logic TX_LAST_O,
  input wire logic TX_READY_I
);
  logic [4:0] idx_q;
  logic sec_q, long_q, cse_q, rd_q, wr_q;
  logic [4:0] sf_idx;
  logic req;
  logic take;

  assign req = HSEL_I & HREADY_I & HTRANS_I[1];
  assign take = TX_VALID_O & TX_READY_I;
  // superframe position depends on address length and security
  assign sf_idx = 5'h05 + (long_q ? 5'h08 : 5'h02) + (sec_q ? 5'h05 : 5'h00);

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      idx_q <= 5'h00;
      {sec_q, long_q, cse_q, rd_q, wr_q} <= 5'h00;
    end else begin
      rd_q <= req & !HWRITE_I;
      wr_q <= req & HWRITE_I & (HADDR_I[7:2] == 6'h00);
      if (take) begin
        idx_q <= TX_LAST_O ? 5'h00 : idx_q + 5'h01;
        if (idx_q == 5'h00) sec_q <= TX_DATA_O[3];
        if (idx_q == 5'h01) long_q <= TX_DATA_O[6];
        if (idx_q == sf_idx + 5'h01) cse_q <= TX_DATA_O[7];
      end
    end
  end

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  AST_HOLD: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O
    && $stable(TX_DATA_O) && $stable(TX_LAST_O)) else $error("octet moved");
  AST_START: assert property ($rose(TX_VALID_O) |-> $past(wr_q)
    && idx_q == 5'h00) else $error("frame start late");
  AST_FC_LO: assert property (TX_VALID_O && idx_q == 5'h00 |->
    TX_DATA_O[7:5] == 3'h0 && TX_DATA_O[2:0] == bhb_pkg::FT_BEACON)
    else $error("control low octet");
  AST_FC_HI: assert property (TX_VALID_O && idx_q == 5'h01 |->
    TX_DATA_O[7] && TX_DATA_O[5:0] == 6'h00) else $error("control high");
  AST_SF_RSV: assert property (TX_VALID_O && idx_q == sf_idx + 5'h01
    |-> !TX_DATA_O[4]) else $error("superframe reserved bit");
  AST_GTS_RSV: assert property (TX_VALID_O && idx_q == sf_idx + 5'h02
    |-> TX_DATA_O[6:3] == 4'h0) else $error("slot spec reserved bits");
  AST_LAST_POS: assert property (TX_VALID_O && TX_LAST_O |->
    idx_q == sf_idx + 5'h02 + {4'h0, cse_q}) else $error("last misplaced");
  AST_LAST_END: assert property (take && TX_LAST_O |=> !TX_VALID_O ##1
    !TX_VALID_O) else $error("valid after last");
  AST_RD_IDLE: assert property (!rd_q |-> HRDATA_O == 32'h0)
    else $error("read data outside data phase");
  AST_BUS_OK: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus not ready or error");

  COV_LONG: cover property (take && TX_LAST_O && long_q && sec_q);
  COV_STALL: cover property (TX_VALID_O && !TX_READY_I ##1 take);
  COV_CELL: cover property (take && TX_LAST_O && cse_q);
endmodule

bind bhb_top bhb_top_sva #(.MIN_CAP_SLOTS(MIN_CAP_SLOTS)) u_sva (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
  .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .TX_LAST_O(TX_LAST_O),
  .TX_READY_I(TX_READY_I)
);

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic clk, arst_n, hsel, hwrite, hready, hresp, slow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] tx_data, rx_data;
  logic tx_valid, tx_last, tx_slots, tx_ready, rx_start, rx_valid;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] exp_q[$];

  bhb_top #(.MIN_CAP_SLOTS(4'h4)) DUT (
    .CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .TX_DATA_O(tx_data),
    .TX_VALID_O(tx_valid), .TX_LAST_O(tx_last), .TX_SLOTS_FOLLOW_O(tx_slots),
    .TX_READY_I(tx_ready), .RX_START_I(rx_start), .RX_VALID_I(rx_valid),
    .RX_DATA_I(rx_data)
  );

  bhb_sink_model sink (
    .clk_i(clk), .rst_n_i(arst_n), .valid_i(tx_valid), .data_i(tx_data),
    .last_i(tx_last), .slow_i(slow), .ready_o(tx_ready)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // entered just after a rising edge; returns on the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic expect_frame(input logic [8:0] c, input logic [31:0] s,
                              input logic [7:0] sq);
    logic [15:0] fc, sf;
    logic [63:0] a;
    a = 64'hfedcba9876543210;
    fc = {c[2] ? 2'h3 : 2'h2, 9'h000, c[7], c[1], 3'h0};
    sf = {c[6], c[4], c[3], 1'b0, s[11:0]};
    exp_q = {fc[7:0], fc[15:8], sq, 8'h5a, 8'ha5};
    for (int i = 0; i < (c[2] ? 8 : 2); i++) exp_q.push_back(a[8*i +: 8]);
    if (c[1]) exp_q = {exp_q, 8'h0d, 8'h04, 8'h03, 8'h02, 8'h01};
    exp_q = {exp_q, sf[7:0], sf[15:8]};
    exp_q.push_back({c[5], 4'h0, s[14:12]});
    if (c[6]) exp_q.push_back(s[23:16]);
  endtask

  task automatic run_tx(input logic [8:0] c, input logic [31:0] s,
                        input logic [7:0] sq, input logic sl);
    int f0;
    logic seen;
    f0 = sink.frames;
    seen = 1'b0;
    slow <= sl;
    bus(1'b1, bhb_pkg::REG_SFCFG, s);
    bus(1'b1, bhb_pkg::REG_CTRL, {23'h0, c} | 32'h1);
    for (int i = 0; i < 500 && sink.frames == f0; i++) begin
      @(posedge clk);
      seen |= tx_slots;
    end
    expect_frame(c, s, sq);
    chk("frame length", exp_q.size(), sink.q.size());
    foreach (exp_q[i]) chk("octet", exp_q[i], sink.q[i]);
    chk("slots follow", {31'h0, s[14:12] != 3'h0}, {31'h0, seen});
    bus(1'b0, bhb_pkg::REG_SEQ, 32'h0);
    chk("sequence", {24'h0, 8'(sq + 8'h01)}, rd);
    sink.q.delete();
  endtask

  task automatic refuse();
    int f0;
    f0 = sink.frames;
    bus(1'b1, bhb_pkg::REG_SFCFG, 32'h00000211);
    bus(1'b1, bhb_pkg::REG_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    chk("refused frame", f0, sink.frames);
    bus(1'b0, bhb_pkg::REG_STATUS, 32'h0);
    chk("cap short", 32'h2, rd & 32'h2);
    bus(1'b1, bhb_pkg::REG_STATUS, 32'h2);
    bus(1'b0, bhb_pkg::REG_STATUS, 32'h0);
    chk("cap short clear", 32'h0, rd & 32'h2);
  endtask

  // idle data shows the inverse of the last octet, not a held value
  task automatic rx_send(input logic [7:0] b[$]);
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_data <= b[i];
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~b[i];
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic rx_check();
    bus(1'b1, bhb_pkg::REG_STATUS, 32'h6);
    rx_send('{8'he0, 8'h8f, 8'h33, 8'hef, 8'hbe, 8'h34, 8'h12, 8'h23,
              8'hd1, 8'hfa});
    bus(1'b0, bhb_pkg::REG_RX_SPEC, 32'h0);
    chk("rx spec", 32'h3382c123, rd);
    bus(1'b0, bhb_pkg::REG_RX_SRC, 32'h0);
    chk("rx source", 32'h1234beef, rd);
    bus(1'b0, bhb_pkg::REG_STATUS, 32'h0);
    chk("rx status", 32'h34, rd & 32'h3c);
    rx_send('{8'h01, 8'h80, 8'h00, 8'h00});
    bus(1'b0, bhb_pkg::REG_STATUS, 32'h0);
    chk("rx not beacon", 32'h8, rd & 32'h8);
  endtask

  task automatic reg_reset();
    for (int a = 0; a < 52; a += 4) begin
      bus(1'b0, a[7:0], 32'h0);
      chk("reset value", 32'h0, rd);
    end
    bus(1'b1, 8'h30, 32'hffffffff);
    bus(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask

  initial begin
    arst_n = 1'b0;
    {hsel, hwrite, slow, rx_start, rx_valid} = 5'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    rx_data = 8'h00;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    reg_reset();
    bus(1'b1, bhb_pkg::REG_NETID, 32'h0000a55a);
    bus(1'b1, bhb_pkg::REG_ADDR_LO, 32'h76543210);
    bus(1'b1, bhb_pkg::REG_ADDR_HI, 32'hfedcba98);
    bus(1'b1, bhb_pkg::REG_SEC_CTRL, 32'h0000000d);
    bus(1'b1, bhb_pkg::REG_SEC_CNT, 32'h01020304);
    bus(1'b1, bhb_pkg::REG_SEQ, 32'h000000ff);
    run_tx(9'h0b8, 32'h00117745, 8'hff, 1'b0);
    run_tx(9'h046, 32'h009c0f23, 8'h00, 1'b1);
    refuse();
    run_tx(9'h100, 32'h00000211, 8'h01, 1'b0);
    rx_check();
    tally_and_finish();
  end
endmodule
